// ===== pll_ctrl_pkg.sv
`default_nettype none
package pll_ctrl_pkg;
  // divider widths
  localparam int REF_DIV_W = 4;
  localparam int IN_DIV_W = 14;
  localparam int FB_PRE_W = 8;
  localparam int FB_MAIN_W = 10;
  localparam int PS_W = 3;
  // stabilization timer
  localparam int STAB_TIME_US = 100;
  localparam int CLK_MHZ = 200;
  localparam int STAB_CYCLES = STAB_TIME_US * CLK_MHZ;
  localparam int STAB_W = 16;
  // calibration length in phase-detector reference edges
  localparam int CAL_REF_EDGES = 131072;
  localparam int CAL_W = 18;
  // output format codes
  localparam logic [2:0] FMT_LVDS = 3'h0;
  localparam logic [2:0] FMT_LVPECL = 3'h1;
  localparam logic [2:0] FMT_CML = 3'h2;
  localparam logic [2:0] FMT_HCSL = 3'h3;
  localparam logic [2:0] FMT_CMOS = 3'h4;
  localparam logic [2:0] FMT_OFF = 3'h7;
  localparam int NUM_OUT = 8;
  localparam int CMOS_SEL_W = 2;
  localparam int LF_SEL_W = 4;

  typedef enum logic [2:0] {
    ST_RESET = 3'h0,
    ST_LOAD = 3'h1,
    ST_STAB = 3'h2,
    ST_CAL = 3'h3,
    ST_RUN = 3'h4
  } seq_state_t;
endpackage
`default_nettype wire

// ===== pll_clock_control.sv
// Behaviour
// - device held in reset while power-down or reset pin is low
// - pin release or power-up reloads defaults, then calibrates
// - soft reset bit pulsed high then low recalibrates, keeping registers
// - calibration waits for timer expiry and supplies good
// - all clock outputs held in reset during calibration
// - reference divider is 4-bit counter, ratios 1 to 16
// - input divider is 14-bit counter, ratios 1 to 16384, feeds detector
// - feedback divider: 8-bit stage cascaded into 10-bit stage
// - phase detector compares input divider output with feedback, gives up/down
// - prescaler a clocks outputs 0,1,4,5 and feedback; b clocks 2,3,6,7
// - formats: lvds all, lvpecl/cml on 0-3, hcsl/cmos on 4-7
// - cmos port drives one or two in-phase single-ended signals
// - cmos slew selectable fast or reduced
// - third loop-filter pole r and c chosen by settings
`default_nettype none
module pll_clock_control (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic power_down_pin,
  input wire logic reset_pin,
  input wire logic supplies_ok,
  input wire logic soft_reset_bit,
  input wire logic primary_reference_input,
  input wire logic secondary_ref_input,
  input wire logic use_secondary,
  input wire logic vco_clk,
  input wire logic [pll_ctrl_pkg::REF_DIV_W-1:0] ref_div_set,
  input wire logic [pll_ctrl_pkg::IN_DIV_W-1:0] in_div_set,
  input wire logic [pll_ctrl_pkg::FB_PRE_W-1:0] fb_pre_set,
  input wire logic [pll_ctrl_pkg::FB_MAIN_W-1:0] fb_main_set,
  input wire logic [pll_ctrl_pkg::PS_W-1:0] ps_a_set,
  input wire logic [pll_ctrl_pkg::PS_W-1:0] ps_b_set,
  input wire logic [3*pll_ctrl_pkg::NUM_OUT-1:0] fmt_set,
  input wire logic [pll_ctrl_pkg::NUM_OUT-1:4] cmos_dual_set,
  input wire logic [pll_ctrl_pkg::NUM_OUT-1:4] cmos_slow_set,
  input wire logic [pll_ctrl_pkg::LF_SEL_W-1:0] lf_r3_set,
  input wire logic [pll_ctrl_pkg::LF_SEL_W-1:0] lf_c3_set,
  output logic load_defaults,
  output logic outputs_in_reset,
  output logic cal_active,
  output logic pump_up,
  output logic pump_down,
  output logic prescaler_a,
  output logic prescaler_b,
  output logic [pll_ctrl_pkg::NUM_OUT-1:0] div_clk_en,
  output logic [3*pll_ctrl_pkg::NUM_OUT-1:0] fmt_eff,
  output logic [pll_ctrl_pkg::NUM_OUT-1:4] cmos_comp_out,
  output logic [pll_ctrl_pkg::NUM_OUT-1:4] cmos_slew_fast,
  output logic [pll_ctrl_pkg::LF_SEL_W-1:0] lf_r3,
  output logic [pll_ctrl_pkg::LF_SEL_W-1:0] lf_c3
);
  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] sync1_q, sync2_q;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {power_down_pin, reset_pin, supplies_ok, soft_reset_bit,
                  primary_reference_input, secondary_ref_input, vco_clk};
      sync2_q <= sync1_q;
    end
  end
  logic pdn_s, rstp_s, sup_s, soft_s, pri_s, sec_s, vco_s;
  assign {pdn_s, rstp_s, sup_s, soft_s, pri_s, sec_s, vco_s} = sync2_q;

  // ---------------------------------------------------------------
  // reset sequencing
  // ---------------------------------------------------------------
  logic soft_d1_q, vco_d1_q, pri_d1_q, sec_d1_q;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      soft_d1_q <= 1'b0;
      vco_d1_q <= 1'b0;
      pri_d1_q <= 1'b0;
      sec_d1_q <= 1'b0;
    end else begin
      soft_d1_q <= soft_s;
      vco_d1_q <= vco_s;
      pri_d1_q <= pri_s;
      sec_d1_q <= sec_s;
    end
  end
  logic pins_reset, soft_fall, vco_rise, pri_rise, sec_rise;
  assign pins_reset = !pdn_s || !rstp_s;
  assign soft_fall = soft_d1_q && !soft_s;
  assign vco_rise = vco_s && !vco_d1_q;
  assign pri_rise = pri_s && !pri_d1_q;
  assign sec_rise = sec_s && !sec_d1_q;

  pll_ctrl_pkg::seq_state_t state_q;
  logic [pll_ctrl_pkg::STAB_W-1:0] stab_q;
  logic [pll_ctrl_pkg::CAL_W-1:0] cal_q;
  logic pfd_ref_tick;

  // power-up enters reset so defaults load on the first release
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q <= pll_ctrl_pkg::ST_RESET;
    end else if (pins_reset) begin
      state_q <= pll_ctrl_pkg::ST_RESET;
    end else begin
      case (state_q)
        pll_ctrl_pkg::ST_RESET: state_q <= pll_ctrl_pkg::ST_LOAD;
        pll_ctrl_pkg::ST_LOAD: state_q <= pll_ctrl_pkg::ST_STAB;
        pll_ctrl_pkg::ST_STAB: begin
          // bit held high keeps the device waiting
          if (!soft_s && stab_q == '0 && sup_s) begin
            state_q <= pll_ctrl_pkg::ST_CAL;
          end
        end
        pll_ctrl_pkg::ST_CAL: begin
          if (soft_s) begin
            state_q <= pll_ctrl_pkg::ST_STAB;
          end else if (cal_q == '0) begin
            state_q <= pll_ctrl_pkg::ST_RUN;
          end
        end
        pll_ctrl_pkg::ST_RUN: begin
          if (soft_s) begin
            state_q <= pll_ctrl_pkg::ST_STAB;
          end
        end
        default: state_q <= pll_ctrl_pkg::ST_RESET;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n || state_q == pll_ctrl_pkg::ST_LOAD || soft_s || soft_fall) begin
      stab_q <= pll_ctrl_pkg::STAB_W'(pll_ctrl_pkg::STAB_CYCLES - 1);
    end else if (state_q == pll_ctrl_pkg::ST_STAB && stab_q != '0) begin
      stab_q <= stab_q - 1'b1;
    end
  end

  // calibration counts phase-detector reference edges
  always_ff @(posedge mclk) begin
    if (!rst_n || state_q != pll_ctrl_pkg::ST_CAL) begin
      cal_q <= pll_ctrl_pkg::CAL_W'(pll_ctrl_pkg::CAL_REF_EDGES - 1);
    end else if (pfd_ref_tick && cal_q != '0) begin
      cal_q <= cal_q - 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      load_defaults <= 1'b1;
      outputs_in_reset <= 1'b1;
      cal_active <= 1'b0;
    end else begin
      load_defaults <= pins_reset || state_q == pll_ctrl_pkg::ST_RESET;
      outputs_in_reset <= pins_reset ||
                          state_q != pll_ctrl_pkg::ST_RUN;
      cal_active <= !pins_reset && state_q == pll_ctrl_pkg::ST_CAL;
    end
  end

  // ---------------------------------------------------------------
  // dividers
  // ---------------------------------------------------------------
  // set value holds ratio minus one, so all-ones gives the maximum
  logic [pll_ctrl_pkg::REF_DIV_W-1:0] ref_cnt_q;
  logic [pll_ctrl_pkg::IN_DIV_W-1:0] in_cnt_q;
  logic [pll_ctrl_pkg::FB_PRE_W-1:0] fbp_cnt_q;
  logic [pll_ctrl_pkg::FB_MAIN_W-1:0] fbm_cnt_q;
  logic [pll_ctrl_pkg::PS_W-1:0] psa_cnt_q, psb_cnt_q;
  logic ref_tick, mux_tick, psa_tick, psb_tick, fbp_tick, fb_tick;
  logic div_rst;
  assign div_rst = !rst_n || state_q == pll_ctrl_pkg::ST_RESET;

  assign ref_tick = pri_rise && ref_cnt_q == '0;
  always_ff @(posedge mclk) begin
    if (div_rst) ref_cnt_q <= '0;
    else if (pri_rise) begin
      ref_cnt_q <= (ref_cnt_q == '0) ? ref_div_set : ref_cnt_q - 1'b1;
    end
  end

  assign mux_tick = use_secondary ? sec_rise : ref_tick;
  assign pfd_ref_tick = mux_tick && in_cnt_q == '0;
  always_ff @(posedge mclk) begin
    if (div_rst) in_cnt_q <= '0;
    else if (mux_tick) begin
      in_cnt_q <= (in_cnt_q == '0) ? in_div_set : in_cnt_q - 1'b1;
    end
  end

  assign psa_tick = vco_rise && psa_cnt_q == '0;
  assign psb_tick = vco_rise && psb_cnt_q == '0;
  always_ff @(posedge mclk) begin
    if (div_rst) begin
      psa_cnt_q <= '0;
      psb_cnt_q <= '0;
    end else if (vco_rise) begin
      psa_cnt_q <= (psa_cnt_q == '0) ? ps_a_set : psa_cnt_q - 1'b1;
      psb_cnt_q <= (psb_cnt_q == '0) ? ps_b_set : psb_cnt_q - 1'b1;
    end
  end

  // feedback is clocked from prescaler a only
  assign fbp_tick = psa_tick && fbp_cnt_q == '0;
  assign fb_tick = fbp_tick && fbm_cnt_q == '0;
  always_ff @(posedge mclk) begin
    if (div_rst) begin
      fbp_cnt_q <= '0;
      fbm_cnt_q <= '0;
    end else begin
      if (psa_tick) begin
        fbp_cnt_q <= (fbp_cnt_q == '0) ? fb_pre_set : fbp_cnt_q - 1'b1;
      end
      if (fbp_tick) begin
        fbm_cnt_q <= (fbm_cnt_q == '0) ? fb_main_set : fbm_cnt_q - 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (div_rst) begin
      prescaler_a <= 1'b0;
      prescaler_b <= 1'b0;
    end else begin
      if (psa_tick) prescaler_a <= !prescaler_a;
      if (psb_tick) prescaler_b <= !prescaler_b;
    end
  end

  // ---------------------------------------------------------------
  // phase detector
  // ---------------------------------------------------------------
  // coincident edges cancel, as the analog reset path would
  always_ff @(posedge mclk) begin
    if (div_rst) begin
      pump_up <= 1'b0;
      pump_down <= 1'b0;
    end else if (pfd_ref_tick && fb_tick) begin
      pump_up <= 1'b0;
      pump_down <= 1'b0;
    end else if (pfd_ref_tick) begin
      if (pump_down) pump_down <= 1'b0;
      else pump_up <= 1'b1;
    end else if (fb_tick) begin
      if (pump_up) pump_up <= 1'b0;
      else pump_down <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // output gating and formats
  // ---------------------------------------------------------------
  logic [pll_ctrl_pkg::NUM_OUT-1:0] fmt_ok;
  genvar g;
  generate
    for (g = 0; g < pll_ctrl_pkg::NUM_OUT; g++) begin : g_out
      logic [2:0] f;
      assign f = fmt_set[3*g +: 3];
      if (g < 4) begin : g_lo
        assign fmt_ok[g] = f == pll_ctrl_pkg::FMT_LVDS ||
          f == pll_ctrl_pkg::FMT_LVPECL || f == pll_ctrl_pkg::FMT_CML;
      end else begin : g_hi
        assign fmt_ok[g] = f == pll_ctrl_pkg::FMT_LVDS ||
          f == pll_ctrl_pkg::FMT_HCSL || f == pll_ctrl_pkg::FMT_CMOS;
      end
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          fmt_eff[3*g +: 3] <= pll_ctrl_pkg::FMT_OFF;
        end else begin
          // unsupported format parks the buffer off
          fmt_eff[3*g +: 3] <= fmt_ok[g] ? f : pll_ctrl_pkg::FMT_OFF;
        end
      end
    end
  endgenerate

  // a-prescaler domain outputs 0,1,4,5; b domain 2,3,6,7
  localparam logic [pll_ctrl_pkg::NUM_OUT-1:0] A_GROUP = 8'h33;
  always_ff @(posedge mclk) begin
    if (!rst_n || outputs_in_reset || pins_reset ||
        state_q != pll_ctrl_pkg::ST_RUN) begin
      div_clk_en <= '0;
    end else begin
      div_clk_en <= (A_GROUP & {pll_ctrl_pkg::NUM_OUT{psa_tick}}) |
                    (~A_GROUP & {pll_ctrl_pkg::NUM_OUT{psb_tick}});
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cmos_comp_out <= '0;
      cmos_slew_fast <= '1;
      lf_r3 <= '0;
      lf_c3 <= '0;
    end else begin
      // set means second leg driven in phase, never inverted
      cmos_comp_out <= cmos_dual_set;
      cmos_slew_fast <= ~cmos_slow_set;
      lf_r3 <= lf_r3_set;
      lf_c3 <= lf_c3_set;
    end
  end
endmodule
`default_nettype wire

// ===== pll_clock_control_asserts.sv
`default_nettype none
module pll_clock_control_asserts (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic power_down_pin,
  input wire logic reset_pin,
  input wire logic soft_reset_bit,
  input wire logic [7:4] cmos_dual_set,
  input wire logic [7:4] cmos_slow_set,
  input wire logic [3:0] lf_r3_set,
  input wire logic load_defaults,
  input wire logic outputs_in_reset,
  input wire logic cal_active,
  input wire logic [7:0] div_clk_en,
  input wire logic [7:4] cmos_comp_out,
  input wire logic [7:4] cmos_slew_fast,
  input wire logic [3:0] lf_r3
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------
  // helpers
  // --------
  logic [1:0] up_q;
  logic [15:0] stab_q;
  wire ok = &up_q;
  always_ff @(posedge mclk) begin
    if (!rst_n) up_q <= 2'h0;
    else if (!ok) up_q <= up_q + 2'h1;
  end
  // starts up to three cycles before the real timer stops reloading after a soft reset, so it can over-count
  always_ff @(posedge mclk) begin
    if (!rst_n || load_defaults || soft_reset_bit || cal_active)
      stab_q <= 16'h0;
    else if (stab_q != 16'hffff)
      stab_q <= stab_q + 16'h1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // --------
  // checks
  // --------
  chk_pins_hold_reset: assert property (
    (!power_down_pin || !reset_pin)[*4] |->
      load_defaults && outputs_in_reset)
    else $error("pin low but device not in reset");
  chk_cal_outs_quiet: assert property (
    cal_active |-> outputs_in_reset && div_clk_en == 8'h0)
    else $error("outputs running during calibration");
  chk_stab_timer: assert property (
    $rose(cal_active) |-> stab_q >= pll_ctrl_pkg::STAB_CYCLES)
    else $error("calibration before timer expiry");
  chk_soft_exit: assert property (
    $rose(soft_reset_bit) && cal_active |-> ##[1:4] !cal_active)
    else $error("soft reset did not leave calibration");
  chk_soft_wait: assert property (
    soft_reset_bit[*5] |-> !cal_active)
    else $error("calibrating while soft bit held high");
  chk_cmos_phase: assert property (
    (ok && $stable(cmos_dual_set))[*3] |-> cmos_comp_out == cmos_dual_set)
    else $error("cmos pair mode mismatch");
  chk_cmos_slew: assert property (
    (ok && $stable(cmos_slow_set))[*3] |->
      cmos_slew_fast == ~cmos_slow_set)
    else $error("cmos slew mismatch");
  chk_pole_res: assert property (
    (ok && $stable(lf_r3_set))[*3] |-> lf_r3 == lf_r3_set)
    else $error("third pole resistor mismatch");
  cover property ($rose(cal_active));
  cover property ($fell(soft_reset_bit) && !cal_active);
  cover property ($fell(load_defaults));
endmodule
`default_nettype wire

// ===== pll_host_model.sv
`default_nettype none
module pll_host_model (
  input wire logic mclk,
  input wire logic pdn_req,
  input wire logic rst_req,
  input wire logic soft_req,
  input wire logic sup_req,
  output logic power_down_pin,
  output logic reset_pin,
  output logic soft_reset_bit,
  output logic supplies_ok,
  output logic primary_reference_input,
  output logic secondary_ref_input,
  output logic vco_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------
  // host side
  // --------
  logic [2:0] div_q = 3'h0;
  // slow clocks, below mclk/4 so every edge is seen
  always @(negedge mclk) div_q <= div_q + 3'h1;
  assign primary_reference_input = div_q[2];
  assign secondary_ref_input = ~div_q[2];
  // far too slow to push any first stage past its limit
  assign vco_clk = div_q[2];
  assign power_down_pin = pdn_req;
  assign reset_pin = rst_req;
  // idles low, raised and later lowered by the bench
  assign soft_reset_bit = soft_req;
  assign supplies_ok = sup_req;
endmodule
`default_nettype wire

// ===== pll_clock_control_tb_top.sv
`default_nettype none
module pll_clock_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // --------
  // signals
  // --------
  logic mclk, rst_n, pdn_req, rst_req, soft_req, sup_req, use_secondary;
  logic [3:0] ref_div_set, lf_r3_set, lf_c3_set, lf_r3, lf_c3;
  logic [13:0] in_div_set;
  logic [7:0] fb_pre_set, div_clk_en;
  logic [9:0] fb_main_set;
  logic [2:0] ps_a_set, ps_b_set;
  logic [23:0] fmt_set, fmt_eff;
  logic [7:4] cmos_dual_set, cmos_slow_set, cmos_comp_out, cmos_slew_fast;
  logic load_defaults, outputs_in_reset, cal_active, pump_up, pump_down;
  logic prescaler_a, prescaler_b;
  wire power_down_pin, reset_pin, soft_reset_bit, supplies_ok;
  wire primary_reference_input, secondary_ref_input, vco_clk;
  int check_count = 0;
  int miscompares = 0;
  int n;
  logic [95:0] r;
  int up_n, dn_n, a_n, b_n;
  logic a_p, b_p;
  // host model's slow clocks run at one eighth of mclk
  localparam int SLOW_PER = 8;
  // multiple of every toggle spacing used below, so counts are exact
  localparam int WIN = 192;
`define CHK(nm, e, a) begin \
  check_count++; \
  if ((a) !== (e)) begin \
    miscompares++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, a); \
  end \
end
  pll_host_model host (.*);
  pll_clock_control DUT (.*);
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // --------
  // helpers
  // --------
  function automatic logic [23:0] fmt_exp(input logic [23:0] f);
    logic [2:0] c;
    fmt_exp = '1;
    for (int i = 0; i < 8; i++) begin
      c = f[3*i+:3];
      if (c == 3'h0 || (i < 4 && c inside {3'h1, 3'h2}) ||
          (i > 3 && c inside {3'h3, 3'h4}))
        fmt_exp[3*i+:3] = c;
    end
  endfunction
  task automatic tick(input int k);
    repeat (k) @(negedge mclk);
  endtask
  task automatic cfg();
    r = {$urandom, $urandom, $urandom};
    {ref_div_set, in_div_set, fb_pre_set, fb_main_set, ps_a_set, ps_b_set,
     fmt_set, cmos_dual_set, cmos_slow_set, lf_r3_set, lf_c3_set} = r[81:0];
  endtask
  task automatic results();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wait_cal(input int lim);
    n = 0;
    while (cal_active !== 1'b1 && n < lim) begin
      @(negedge mclk);
      n++;
    end
    if (n >= lim) begin
      miscompares++;
      $display("CHECK FAILED cal_active exp 1 got %0h", cal_active);
      results();
    end
  endtask
  // --------
  // tests
  // --------
  initial begin
    n = $urandom(32'hf258);
    {rst_n, pdn_req, rst_req, soft_req, sup_req} = 5'h0;
    use_secondary = 1'b0;
    cfg();
    tick(6);
    rst_n = 1'b1;
    tick(4);
    `CHK("load_defaults", 1'b1, load_defaults)
    `CHK("outputs_in_reset", 1'b1, outputs_in_reset)
    $display("test pins low done");
    {pdn_req, rst_req} = 2'h3;
    tick(6);
    `CHK("load_defaults", 1'b0, load_defaults)
    for (int k = 0; k < 10; k++) begin
      cfg();
      if (k < 2)
        fmt_set = k ? 24'h053977 : 24'hfac688;
      tick(4);
      `CHK("fmt_eff", fmt_exp(fmt_set), fmt_eff)
      `CHK("cmos_comp_out", cmos_dual_set, cmos_comp_out)
      `CHK("cmos_slew_fast", ~cmos_slow_set, cmos_slew_fast)
      `CHK("lf_r3", lf_r3_set, lf_r3)
      `CHK("lf_c3", lf_c3_set, lf_c3)
    end
    $display("test formats done");
    tick(pll_ctrl_pkg::STAB_CYCLES + 100);
    `CHK("cal_active", 1'b0, cal_active)
    sup_req = 1'b1;
    wait_cal(20);
    `CHK("outputs_in_reset", 1'b1, outputs_in_reset)
    $display("test calibration entry done");
    soft_req = 1'b1;
    tick(100);
    `CHK("cal_active", 1'b0, cal_active)
    `CHK("load_defaults", 1'b0, load_defaults)
    soft_req = 1'b0;
    wait_cal(pll_ctrl_pkg::STAB_CYCLES + 50);
    `CHK("soft wait", 1'b1, n >= pll_ctrl_pkg::STAB_CYCLES)
    $display("test soft reset done");
    for (int k = 0; k < 2; k++) begin
      {pdn_req, rst_req} = k ? 2'h2 : 2'h1;
      // small ratios set while dividers are held cleared by the pin
      ref_div_set = 4'h0;
      in_div_set = 14'(k);
      ps_a_set = 3'h0;
      ps_b_set = 3'(k + 1);
      fb_pre_set = 8'h0;
      fb_main_set = 10'(1 - k);
      tick(4 + $urandom_range(4));
      `CHK("load_defaults", 1'b1, load_defaults)
      `CHK("cal_active", 1'b0, cal_active)
      {pdn_req, rst_req} = 2'h3;
      wait_cal(pll_ctrl_pkg::STAB_CYCLES + 50);
      `CHK("pin wait", 1'b1, n >= pll_ctrl_pkg::STAB_CYCLES)
      up_n = 0;
      dn_n = 0;
      a_n = 0;
      b_n = 0;
      a_p = prescaler_a;
      b_p = prescaler_b;
      repeat (WIN) begin
        @(negedge mclk);
        up_n += int'(pump_up);
        dn_n += int'(pump_down);
        a_n += int'(prescaler_a !== a_p);
        b_n += int'(prescaler_b !== b_p);
        a_p = prescaler_a;
        b_p = prescaler_b;
      end
      // k 0: reference twice as fast as feedback; k 1: the reverse
      `CHK("pump_up", k == 0, up_n > 0)
      `CHK("pump_down", k == 1, dn_n > 0)
      `CHK("prescaler_a", WIN / SLOW_PER, a_n)
      `CHK("prescaler_b", WIN / (SLOW_PER * (k + 2)), b_n)
    end
    $display("test pin reset done");
    results();
  end
endmodule
bind pll_clock_control pll_clock_control_asserts chk_i (.*);
`default_nettype wire
